// ===== hw/dosd_defines.svh
`ifndef DOSD_DEFINES_SVH
`define DOSD_DEFINES_SVH

// Clock rate and the per-ID spin-up delay step
`define DOSD_CLK_HZ          200000000
`define DOSD_DELAY_STEP_SEC  12
// Cycles in one whole second at the core clock
`define DOSD_CYC_PER_SEC     (`DOSD_CLK_HZ)
// Settling cycles after reset release before straps are captured
`define DOSD_SETTLE_CYC      16
// Reset value of the applied bus ID
`define DOSD_RST_ID          4'h0

`endif

// ===== hw/dosd_pkg.sv
package dosd_pkg;

    // One set of strap levels, one source
    typedef struct packed {
        logic [3:0] bus_id;
        logic       force_single_ended;
        logic       delayed_start_sel;
        logic       motor_start_on_cmd;
        logic       write_protect;
        logic       parity_disable_strap;
    } dosd_straps_t;

    typedef enum logic [2:0] {
        DOSD_SETTLE,
        DOSD_DECIDE,
        DOSD_DELAY,
        DOSD_WAIT_CMD,
        DOSD_SPIN
    } dosd_spin_state_t;

endpackage : dosd_pkg

// ===== hw/dosd_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; output changes when stages two and three agree
module dosd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] next_level;

    // Accept a bit only once it is seen stable for two stages
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (s2[i] == s3[i]) ? s2[i] : level_o[i];
        end
    end

    // Meta is read only by s2
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta    <= '0;
            s2      <= '0;
            s3      <= '0;
            level_o <= '0;
        end else begin
            meta    <= pin_i;
            s2      <= meta;
            s3      <= s2;
            level_o <= next_level;
        end
    end
endmodule : dosd_sync

`default_nettype wire

// ===== hw/dosd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dosd_defines.svh"

module dosd_top #(
    parameter int unsigned CYC_PER_SEC = `DOSD_CYC_PER_SEC,
    parameter int unsigned STEP_SEC    = `DOSD_DELAY_STEP_SEC
) (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  cabled_variant_i,
    input  wire dosd_pkg::dosd_straps_t header_straps_i,
    input  wire dosd_pkg::dosd_straps_t host_io_straps_i,
    input  wire logic                  differential_sense_line_i,
    input  wire logic                  start_unit_cmd_i,
    input  wire logic                  write_req_i,
    input  wire logic                  rx_parity_valid_i,
    input  wire logic                  rx_parity_ok_i,
    output logic                       lvd_mode_o,
    output logic                       spindle_start_o,
    output logic                       write_allow_o,
    output logic                       write_refused_o,
    output logic                       parity_check_en_o,
    output logic                       parity_error_o,
    output logic [3:0]                 bus_id_o,
    output logic                       straps_latched_o
);
    localparam int SW = $bits(dosd_pkg::dosd_straps_t);

    logic [SW-1:0]          hdr_sync;
    logic [SW-1:0]          host_sync;
    logic                   sense_sync;
    logic                   variant_sync;
    dosd_pkg::dosd_straps_t strap_sel;

    // Pins come from outside the clock domain
    dosd_sync #(.WIDTH(SW)) u_sync_hdr (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .pin_i      (header_straps_i),
        .level_o    (hdr_sync)
    );
    dosd_sync #(.WIDTH(SW)) u_sync_host (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .pin_i      (host_io_straps_i),
        .level_o    (host_sync)
    );
    dosd_sync #(.WIDTH(2)) u_sync_misc (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .pin_i      ({differential_sense_line_i, cabled_variant_i}),
        .level_o    ({sense_sync, variant_sync})
    );

    // Source select by variant
    assign strap_sel = variant_sync ? dosd_pkg::dosd_straps_t'(host_sync)
                                    : dosd_pkg::dosd_straps_t'(hdr_sync);

    dosd_pkg::dosd_spin_state_t state;
    dosd_pkg::dosd_spin_state_t next_state;
    dosd_pkg::dosd_straps_t     cfg;
    dosd_pkg::dosd_straps_t     next_cfg;
    logic [31:0]                sec_cnt;
    logic [31:0]                next_sec_cnt;
    logic [7:0]                 sec_left;
    logic [7:0]                 next_sec_left;
    logic                       next_spindle;
    logic                       next_latched;

    // Startup sequencer; settle lets synchronisers fill before capture
    always_comb begin
        next_state    = state;
        next_cfg      = cfg;
        next_sec_cnt  = sec_cnt;
        next_sec_left = sec_left;
        next_spindle  = spindle_start_o;
        next_latched  = straps_latched_o;
        case (state)
            dosd_pkg::DOSD_SETTLE: begin
                next_sec_cnt = sec_cnt + 32'h1;
                if (sec_cnt == 32'(`DOSD_SETTLE_CYC)) begin
                    next_cfg     = strap_sel;
                    next_latched = 1'b1;
                    next_sec_cnt = '0;
                    next_state   = dosd_pkg::DOSD_DECIDE;
                end
            end
            dosd_pkg::DOSD_DECIDE: begin
                // Start-on-command overrides the delay
                if (cfg.motor_start_on_cmd) begin
                    next_state = dosd_pkg::DOSD_WAIT_CMD;
                end else if (cfg.delayed_start_sel && cfg.bus_id != 4'h0) begin
                    next_sec_left = 8'(cfg.bus_id * STEP_SEC);
                    next_state    = dosd_pkg::DOSD_DELAY;
                end else begin
                    next_spindle = 1'b1;
                    next_state   = dosd_pkg::DOSD_SPIN;
                end
            end
            dosd_pkg::DOSD_DELAY: begin
                // Whole seconds counted from the core clock
                if (sec_cnt == 32'(CYC_PER_SEC - 1)) begin
                    next_sec_cnt  = '0;
                    next_sec_left = sec_left - 8'h1;
                    if (sec_left == 8'h1) begin
                        next_spindle = 1'b1;
                        next_state   = dosd_pkg::DOSD_SPIN;
                    end
                end else begin
                    next_sec_cnt = sec_cnt + 32'h1;
                end
            end
            dosd_pkg::DOSD_WAIT_CMD: begin
                if (start_unit_cmd_i) begin
                    next_spindle = 1'b1;
                    next_state   = dosd_pkg::DOSD_SPIN;
                end
            end
            dosd_pkg::DOSD_SPIN: begin
                next_spindle = 1'b1;
            end
            default: next_state = dosd_pkg::DOSD_SETTLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state            <= dosd_pkg::DOSD_SETTLE;
            cfg              <= '0;
            sec_cnt          <= '0;
            sec_left         <= '0;
            spindle_start_o  <= 1'b0;
            straps_latched_o <= 1'b0;
        end else begin
            state            <= next_state;
            cfg              <= next_cfg;
            sec_cnt          <= next_sec_cnt;
            sec_left         <= next_sec_left;
            spindle_start_o  <= next_spindle;
            straps_latched_o <= next_latched;
        end
    end

    logic       next_lvd;
    logic       next_wallow;
    logic       next_wref;
    logic       next_pen;
    logic       next_perr;

    // Applied settings; safe values until capture (no writes, single-ended mode)
    always_comb begin
        next_lvd    = straps_latched_o && !cfg.force_single_ended && sense_sync;
        next_wallow = straps_latched_o && !cfg.write_protect;
        next_wref   = write_req_i && !next_wallow;
        next_pen    = straps_latched_o && !cfg.parity_disable_strap;
        next_perr   = next_pen && rx_parity_valid_i && !rx_parity_ok_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvd_mode_o        <= 1'b0;
            write_allow_o     <= 1'b0;
            write_refused_o   <= 1'b0;
            parity_check_en_o <= 1'b0;
            parity_error_o    <= 1'b0;
            bus_id_o          <= `DOSD_RST_ID;
        end else begin
            lvd_mode_o        <= next_lvd;
            write_allow_o     <= next_wallow;
            write_refused_o   <= next_wref;
            parity_check_en_o <= next_pen;
            parity_error_o    <= next_perr;
            bus_id_o          <= cfg.bus_id;
        end
    end

    // Assertions
    force_single_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        straps_latched_o && cfg.force_single_ended |=> !lvd_mode_o)
        else $error("lvd mode while single-ended forced");
    sense_follow_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        straps_latched_o && !cfg.force_single_ended |=> lvd_mode_o == $past(sense_sync))
        else $error("bus mode does not follow sense line");
    immediate_start_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state == dosd_pkg::DOSD_DECIDE && !cfg.motor_start_on_cmd && !cfg.delayed_start_sel
        |=> spindle_start_o)
        else $error("spindle did not start at once");
    cmd_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state == dosd_pkg::DOSD_WAIT_CMD && !start_unit_cmd_i |=> !spindle_start_o)
        else $error("spindle started without command");
    cmd_start_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state == dosd_pkg::DOSD_WAIT_CMD && start_unit_cmd_i |=> spindle_start_o)
        else $error("start command ignored");
    delay_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state == dosd_pkg::DOSD_DELAY |-> !spindle_start_o && sec_left != 8'h0)
        else $error("spindle ran during delay");
    wp_refuse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        straps_latched_o && cfg.write_protect && write_req_i |=> write_refused_o && !write_allow_o)
        else $error("write passed while protected");
    parity_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        straps_latched_o && cfg.parity_disable_strap |=> !parity_error_o && !parity_check_en_o)
        else $error("parity reported while disabled");
    parity_report_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        straps_latched_o && !cfg.parity_disable_strap && rx_parity_valid_i && !rx_parity_ok_i
        |=> parity_error_o)
        else $error("parity error not reported");
    cfg_frozen_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        straps_latched_o |=> $stable(cfg))
        else $error("straps changed after capture");
    // Applied outputs settle one edge after capture, so look two edges on
    opts_frozen_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        straps_latched_o && $past(straps_latched_o, 2)
        |-> $stable(bus_id_o) && $stable(write_allow_o) && $stable(parity_check_en_o))
        else $error("applied options moved after capture");

    cmd_start_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state == dosd_pkg::DOSD_WAIT_CMD ##1 spindle_start_o);
    delay_start_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        state == dosd_pkg::DOSD_DELAY ##1 state == dosd_pkg::DOSD_SPIN);
    wp_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) write_refused_o);
    perr_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) parity_error_o);
endmodule : dosd_top

`default_nettype wire

// ===== verification/dosd_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Initiator side: command pulses and the cabled-variant strap lines
module dosd_host_model (
    input  wire logic                   core_clk_i,
    output var dosd_pkg::dosd_straps_t  io_straps_o,
    output logic                        start_unit_o,
    output logic                        write_o,
    output logic                        par_valid_o,
    output logic                        par_ok_o
);
    // Idle bus at time zero
    initial begin
        io_straps_o  = '0;
        start_unit_o = 1'b0;
        write_o      = 1'b0;
        par_valid_o  = 1'b0;
        par_ok_o     = 1'b1;
    end

    // ID 7 belongs to the adapter, so a device is never handed it
    task set_straps(input dosd_pkg::dosd_straps_t s);
        dosd_pkg::dosd_straps_t v;
        v = s;
        if (s.bus_id == 4'h7) begin
            v.bus_id = 4'h6;
        end
        io_straps_o = v; // One assignment per time step
    endtask : set_straps

    // One-cycle request: 0 start, 1 write, 2 good parity, 3 bad parity
    task pulse(input int kind);
        @(negedge core_clk_i);
        start_unit_o = (kind == 0);
        write_o      = (kind == 1);
        par_valid_o  = (kind >= 2);
        par_ok_o     = (kind == 2);
        @(negedge core_clk_i);
        start_unit_o = 1'b0;
        write_o      = 1'b0;
        par_valid_o  = 1'b0;
        par_ok_o     = ~par_ok_o; // Stale qualifier never looks valid
    endtask : pulse
endmodule : dosd_host_model

`default_nettype wire

// ===== verification/dosd_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module dosd_top_tb_top;
    localparam int unsigned CPS  = 4; // Short seconds keep the delay test brief
    localparam int unsigned STEP = 12;

    typedef struct {
        string       nm;
        logic [10:0] exp;
        logic [10:0] msk;
    } dosd_note_t;

    logic                   core_clk   = 1'b1;
    logic                   rst_n      = 1'b0;
    logic                   cab        = 1'b0;
    logic                   sense      = 1'b0;
    dosd_pkg::dosd_straps_t hdr        = '0;
    dosd_pkg::dosd_straps_t io;
    logic                   start_cmd, wr, pv, pok;
    logic                   lvd, spin, allow, refused, pchk, perr, latched;
    logic [3:0]             bus_id;
    wire logic [10:0]       obs;
    int                     err_total  = 0;
    int                     n_compared = 0;
    int                     seed       = 32'h2c12753b;
    dosd_note_t             notes[$];
    dosd_note_t             cur;

    // Outputs gathered for the scoreboard
    assign obs = {lvd, spin, allow, refused, pchk, perr, bus_id, latched};

    always #2.5 core_clk = ~core_clk;

    dosd_host_model host_u (.core_clk_i(core_clk), .io_straps_o(io), .start_unit_o(start_cmd),
        .write_o(wr), .par_valid_o(pv), .par_ok_o(pok));

    dosd_top #(.CYC_PER_SEC(CPS), .STEP_SEC(STEP)) dut_u (.core_clk_i(core_clk),
        .rst_n_i(rst_n), .cabled_variant_i(cab), .header_straps_i(hdr),
        .host_io_straps_i(io), .differential_sense_line_i(sense),
        .start_unit_cmd_i(start_cmd), .write_req_i(wr), .rx_parity_valid_i(pv),
        .rx_parity_ok_i(pok), .lvd_mode_o(lvd), .spindle_start_o(spin),
        .write_allow_o(allow), .write_refused_o(refused), .parity_check_en_o(pchk),
        .parity_error_o(perr), .bus_id_o(bus_id), .straps_latched_o(latched));

    task check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task note(input string nm, input logic [10:0] e, input logic [10:0] m);
        notes.push_back('{nm, e, m});
    endtask : note

    // Scoreboard: just after each falling edge, outputs are settled mid-cycle
    always @(negedge core_clk) begin
        #1;
        while (notes.size() != 0) begin
            cur = notes.pop_front();
            check(cur.nm, obs & cur.msk, cur.exp & cur.msk);
        end
    end

    task close_out;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // One power cycle; the unused strap source shows the opposite settings
    task automatic session(input logic c, input dosd_pkg::dosd_straps_t s, input logic sn);
        logic [10:0] cfg;
        int          m;
        int          d;
        @(negedge core_clk);
        rst_n = 1'b0;
        cab   = c;
        sense = sn;
        hdr   = c ? ~s : s;
        host_u.set_straps(c ? s : ~s);
        repeat (3) @(negedge core_clk);
        note("reset", 11'h000, 11'h7ff);
        rst_n = 1'b1;
        m = 0;
        while (latched !== 1'b1 && m < 100) begin
            @(negedge core_clk);
            m++;
        end
        check("latch_wait", 11'(m < 100), 11'h001);
        if (m == 100) begin
            close_out();
        end
        d = s.delayed_start_sel ? s.bus_id * STEP * CPS : 0;
        m = 0;
        while (spin !== 1'b1 && m < 300) begin
            @(negedge core_clk);
            m++;
        end
        if (s.motor_start_on_cmd) begin
            note("spin_hold", 11'h000, 11'h200);
        end else begin
            check("spin_delay", 11'(m >= d && m <= d + 6), 11'h001);
            if (m == 300) begin
                close_out();
            end
        end
        cfg = {sn & ~s.force_single_ended, ~s.motor_start_on_cmd, ~s.write_protect, 1'b0,
               ~s.parity_disable_strap, 1'b0, s.bus_id, 1'b1};
        note("settings", cfg, 11'h7ff);
        cab = ~c;
        hdr = ~hdr;
        host_u.set_straps(~io);
        repeat (8) @(negedge core_clk);
        note("after_change", cfg, 11'h7ff);
        host_u.pulse(1);
        note("write", cfg | (11'(s.write_protect) << 7), 11'h7ff);
        host_u.pulse(3);
        note("parity_bad", cfg | (s.parity_disable_strap ? 11'h000 : 11'h020), 11'h7ff);
        host_u.pulse(2);
        note("parity_good", cfg, 11'h7ff);
        if (s.motor_start_on_cmd) begin
            host_u.pulse(0);
            note("start_unit", cfg | 11'h200, 11'h7ff);
        end
    endtask : session

    // Straps order: id, single-ended, delayed, on-command, protect, parity-off
    initial begin
        logic [3:0] rid;
        rid = 4'($random(seed));
        if (rid == 4'h7) begin
            rid = 4'h9;
        end
        session(1'b0, {4'h2, 5'b01010}, 1'b1);
        session(1'b1, {rid, 5'b10101}, 1'b1);
        session(1'b0, {4'h0, 5'b01000}, 1'b0);
        session(1'b1, {4'h3, 5'b01111}, 1'b1);
        repeat (2) @(negedge core_clk);
        close_out();
    end
endmodule : dosd_top_tb_top

`default_nettype wire
